/* File: rtl/csa_pkg.sv */
package csa_pkg;

   // special-function bus offsets
   localparam logic [7:0] OFS_STACK_POINTER_LOW = 8'h81;
   localparam logic [7:0] OFS_WAIT_STATE_CONTROL = 8'h92;
   localparam logic [7:0] OFS_STACK_POINTER_HIGH = 8'h9b;
   localparam logic [7:0] OFS_ADDRESSING_MODE_CONTROL = 8'h9d;
   localparam logic [7:0] OFS_INTERRUPT_PROGRESS_STATUS = 8'hc5;
   localparam logic [7:0] OFS_EXTERNAL_DATA_MEMORY_RELOCATION = 8'hc6;
   localparam logic [7:0] OFS_PROGRAM_STATUS_WORD = 8'hd0;
   localparam logic [7:0] OFS_MULTIPLY_AUX_REGISTER = 8'hf0;

   // reset values
   localparam logic [7:0] RST_STACK_POINTER_LOW = 8'h00;
   localparam logic [7:0] RST_STACK_POINTER_HIGH = 8'h00;
   localparam logic [3:0] RST_WAIT_STATE = 4'h7;
   localparam logic [7:0] RST_ADDRESSING_MODE_CONTROL = 8'h00;
   localparam logic [7:0] RST_EXTERNAL_DATA_MEMORY_RELOCATION = 8'h00;
   localparam logic [7:0] RST_PROGRAM_STATUS_WORD = 8'h00;
   localparam logic [7:0] RST_MULTIPLY_AUX_REGISTER = 8'h00;

   // program status word fields
   localparam int POS_CARRY_FLAG = 7;
   localparam int POS_AUX_CARRY_FLAG = 6;
   localparam int POS_GENERAL_FLAG = 5;
   localparam int POS_BANK_SELECT_HIGH = 4;
   localparam int POS_BANK_SELECT_LOW = 3;
   localparam int POS_OVERFLOW_FLAG = 2;
   localparam int POS_USER_FLAG = 1;
   localparam int POS_PARITY_FLAG = 0;

   // interrupt progress status fields
   localparam int POS_HIGH_PRIO_IN_PROGRESS = 6;
   localparam int POS_LOW_PRIO_IN_PROGRESS = 5;

   // addressing mode control fields
   localparam int POS_VECTOR_REGION_SELECT = 5;
   localparam int POS_INDIRECT_HIGH_ADDR_SOURCE = 3;
   localparam int POS_STACK_MODE_INDICATOR = 2;
   localparam int POS_ADDR_MODE_UPPER = 1;
   localparam int POS_ADDR_MODE_LOWER = 0;
   localparam logic [7:0] MASK_ADDRESSING_MODE_WR = 8'h2b;

   // address forming
   localparam int WAIT_FIELD_W = 4;
   localparam int PROG_ADDR_W = 20;
   localparam int DATA_ADDR_W = 16;
   localparam logic [15:0] VECTOR_REGION_BASE = 16'hb000;

endpackage

/* File: rtl/csa_wait_states.sv */
`timescale 1ns/1ns
`default_nettype none

module csa_wait_states
   import csa_pkg::*;
#(
   parameter int WS_W = WAIT_FIELD_W
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // control
   input wire logic [WS_W-1:0] wait_field,
   // fetch handshake
   input wire logic fetch_req,
   output logic fetch_busy,
   output logic fetch_done
);

   initial begin
      if (WS_W < 1 || WS_W > 8) $error("csa_wait_states: WS_W out of range");
   end

   logic busy_ff;
   logic [WS_W-1:0] cnt_ff;

   // a read lasts wait_field+1 cycles; requests during a read are dropped
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         busy_ff <= 1'b0;
         cnt_ff <= '0;
      end else if (!busy_ff && fetch_req) begin
         busy_ff <= 1'b1;
         cnt_ff <= wait_field;
      end else if (busy_ff && cnt_ff == '0) begin
         busy_ff <= 1'b0;
      end else if (busy_ff) begin
         cnt_ff <= cnt_ff - 1'b1;
      end
   end

   assign fetch_busy = busy_ff;
   assign fetch_done = busy_ff && (cnt_ff == '0);

   AST_FETCH_ONE: assert property (@(posedge sys_clk) disable iff (!nrst)
      (!busy_ff && fetch_req && wait_field == '0) |=> fetch_done)
      else $error("zero wait field did not finish in one cycle");

   AST_FETCH_EIGHT: assert property (@(posedge sys_clk) disable iff (!nrst)
      (!busy_ff && fetch_req && wait_field == 4'h7) |=> !fetch_done [*7] ##1 fetch_done)
      else $error("wait field seven did not give an eight-cycle read");

   COV_LONG_READ: cover property (@(posedge sys_clk) disable iff (!nrst)
      !busy_ff && fetch_req && wait_field == 4'hf);

endmodule

`default_nettype wire

/* File: rtl/csa_addr_form.sv */
`timescale 1ns/1ns
`default_nettype none

module csa_addr_form
   import csa_pkg::*;
#(
   parameter int PC_W = PROG_ADDR_W
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // mode controls
   input wire logic extended_mode,
   input wire logic vector_region_select,
   input wire logic indirect_high_addr_source,
   // sources
   input wire logic [PC_W-1:0] pc_next,
   input wire logic [7:0] vector_offset,
   input wire logic [7:0] port_two,
   input wire logic [7:0] indirect_high_addr_register,
   input wire logic [7:0] indirect_low_addr,
   // formed addresses
   output logic [PC_W-1:0] code_addr_ff,
   output logic [15:0] vector_addr_ff,
   output logic [DATA_ADDR_W-1:0] movx_addr_ff
);

   initial begin
      if (PC_W < 17) $error("csa_addr_form: PC_W must exceed 16");
   end

   // program addresses are cut to 16 bits outside extended mode
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         code_addr_ff <= '0;
      end else if (extended_mode) begin
         code_addr_ff <= pc_next;
      end else begin
         code_addr_ff <= {{(PC_W-16){1'b0}}, pc_next[15:0]};
      end
   end

   // vector table placement
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         vector_addr_ff <= 16'h0000;
      end else begin
         vector_addr_ff <= (vector_region_select ? VECTOR_REGION_BASE : 16'h0000)
                           | {8'h00, vector_offset};
      end
   end

   // register-indirect data address stays 16 bits in every mode
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         movx_addr_ff <= '0;
      end else begin
         movx_addr_ff <= {(indirect_high_addr_source ? indirect_high_addr_register
                           : port_two), indirect_low_addr};
      end
   end

   AST_CODE_CUT: assert property (@(posedge sys_clk) disable iff (!nrst)
      !extended_mode |=> code_addr_ff[PC_W-1:16] == '0)
      else $error("program address not cut in sixteen-bit mode");

   AST_VECTOR_BASE: assert property (@(posedge sys_clk) disable iff (!nrst)
      vector_region_select |=> vector_addr_ff[15:12] == 4'hb)
      else $error("vector not in relocated region");

   AST_HIGH_SRC: assert property (@(posedge sys_clk) disable iff (!nrst)
      !indirect_high_addr_source |=> movx_addr_ff[15:8] == $past(port_two))
      else $error("indirect high byte not from port two");

endmodule

`default_nettype wire

/* File: rtl/csa_regs.sv */
// What this block does
// - eight-bit multiply/divide auxiliary, bit-addressable
// - status word flag layout, carry at top
// - push writes above pointer, pop reads at
// - extended mode stack address is high:low
// - read-only high priority progress bit
// - read-only low priority progress bit
// - serial activity status bits read reserved
// - code reads last wait field plus one
// - wait field resets to seven
// - external data relocation in 2KB steps
// - protected registers need timed-access unlock
// - extended mode: 20-bit code, 16-bit stack
// - data addressing always sixteen bits wide
// - mode 00 sixteen-bit, 1x extended
// - vector select moves vectors to B000
// - indirect high byte: port or register
// - read-only stack mode indicator
`timescale 1ns/1ns
`default_nettype none

module csa_regs
   import csa_pkg::*;
#(
   parameter int PC_W = PROG_ADDR_W
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // special-function bus from the core
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   input wire logic sfr_bit_wr,
   input wire logic [2:0] sfr_bit_sel,
   input wire logic sfr_bit_val,
   output logic [7:0] sfr_rdata_ff,
   output logic sfr_hit_ff,
   // timed-access unlock from the protection unit
   input wire logic timed_access_protection,
   // execution side updates
   input wire logic [7:0] acc,
   input wire logic alu_flags_we,
   input wire logic alu_carry,
   input wire logic alu_aux_carry,
   input wire logic alu_overflow,
   input wire logic muldiv_we,
   input wire logic [7:0] muldiv_aux,
   // stack operations
   input wire logic stack_push,
   input wire logic stack_pop,
   output logic stack_wr_ff,
   output logic stack_rd_ff,
   output logic [15:0] stack_addr_ff,
   output logic [7:0] stack_wdata_ff,
   output logic stack_in_data_space_ff,
   // interrupt controller state
   input wire logic hp_in_service,
   input wire logic lp_in_service,
   // program fetch
   input wire logic fetch_req,
   output logic fetch_busy,
   output logic fetch_done,
   input wire logic [PC_W-1:0] pc_next,
   output logic [PC_W-1:0] code_addr_ff,
   // vectors and indirect data moves
   input wire logic [7:0] vector_offset,
   output logic [15:0] vector_addr_ff,
   input wire logic [7:0] port_two,
   input wire logic [7:0] indirect_high_addr_register,
   input wire logic [7:0] indirect_low_addr,
   output logic [DATA_ADDR_W-1:0] movx_addr_ff,
   // decoded controls
   output logic [7:0] bank_select,
   output logic [7:0] external_data_memory_base
);

   initial begin
      if (PC_W != PROG_ADDR_W) $error("csa_regs: PC_W must be 20");
   end

   logic [7:0] multiply_aux_register_ff;
   logic [7:1] program_status_word_ff;
   logic [7:0] stack_pointer_low_ff;
   logic [7:0] stack_pointer_high_ff;
   logic [WAIT_FIELD_W-1:0] wait_state_control_ff;
   logic [7:0] addressing_mode_control_ff;
   logic [7:0] external_data_memory_relocation_ff;
   logic [7:0] interrupt_progress_status_ff;
   logic parity_flag;
   logic extended_mode;
   logic [15:0] stack_full;
   logic [15:0] nxt_stack_up;
   logic [15:0] nxt_stack_down;
   logic [7:0] rd_val;
   logic rd_hit;
   logic [7:0] psw_view;
   logic [7:0] addressing_mode_control_view;

   ////////////////////////////////////////////////////////////////////////
   // decode helpers

   // hit strobes: whole-byte write or single-bit write to one offset
   function automatic logic byte_wr(input logic [7:0] ofs);
      return sfr_wr && (sfr_addr == ofs);
   endfunction

   function automatic logic bit_wr(input logic [7:0] ofs);
      return sfr_bit_wr && (sfr_addr == ofs);
   endfunction

   // only the upper mode bit matters, so 01 also means sixteen-bit mode
   assign extended_mode = addressing_mode_control_ff[POS_ADDR_MODE_UPPER];
   assign parity_flag = ^acc;
   assign psw_view = {program_status_word_ff, parity_flag};
   assign addressing_mode_control_view = {addressing_mode_control_ff[7:3], extended_mode,
                       addressing_mode_control_ff[1:0]};
   assign stack_full = {stack_pointer_high_ff, stack_pointer_low_ff};
   assign nxt_stack_up = stack_full + 16'h0001;
   assign nxt_stack_down = stack_full - 16'h0001;
   assign external_data_memory_base = external_data_memory_relocation_ff;

   // one-hot register bank select for the working register file
   always_comb begin
      bank_select = 8'h00;
      bank_select[{program_status_word_ff[POS_BANK_SELECT_HIGH],
                   program_status_word_ff[POS_BANK_SELECT_LOW]}] = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // auxiliary multiply/divide register

   // bus writes win over the arithmetic unit in the same cycle
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         multiply_aux_register_ff <= RST_MULTIPLY_AUX_REGISTER;
      end else if (byte_wr(OFS_MULTIPLY_AUX_REGISTER)) begin
         multiply_aux_register_ff <= sfr_wdata;
      end else if (bit_wr(OFS_MULTIPLY_AUX_REGISTER)) begin
         multiply_aux_register_ff[sfr_bit_sel] <= sfr_bit_val;
      end else if (muldiv_we) begin
         multiply_aux_register_ff <= muldiv_aux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // program status word; parity is not stored, it tracks the accumulator

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         program_status_word_ff <= RST_PROGRAM_STATUS_WORD[7:1];
      end else if (byte_wr(OFS_PROGRAM_STATUS_WORD)) begin
         program_status_word_ff <= sfr_wdata[7:1];
      end else if (bit_wr(OFS_PROGRAM_STATUS_WORD) && sfr_bit_sel != 3'h0) begin
         program_status_word_ff[sfr_bit_sel] <= sfr_bit_val;
      end else if (alu_flags_we) begin
         program_status_word_ff[POS_CARRY_FLAG] <= alu_carry;
         program_status_word_ff[POS_AUX_CARRY_FLAG] <= alu_aux_carry;
         program_status_word_ff[POS_OVERFLOW_FLAG] <= alu_overflow;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // stack pointer pair; push pre-increments, pop post-decrements

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         stack_pointer_low_ff <= RST_STACK_POINTER_LOW;
      end else if (byte_wr(OFS_STACK_POINTER_LOW)) begin
         stack_pointer_low_ff <= sfr_wdata;
      end else if (stack_push) begin
         stack_pointer_low_ff <= nxt_stack_up[7:0];
      end else if (stack_pop) begin
         stack_pointer_low_ff <= nxt_stack_down[7:0];
      end
   end

   // the high byte only carries or borrows in extended mode
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         stack_pointer_high_ff <= RST_STACK_POINTER_HIGH;
      end else if (byte_wr(OFS_STACK_POINTER_HIGH)) begin
         stack_pointer_high_ff <= sfr_wdata;
      end else if (extended_mode && stack_push) begin
         stack_pointer_high_ff <= nxt_stack_up[15:8];
      end else if (extended_mode && stack_pop) begin
         stack_pointer_high_ff <= nxt_stack_down[15:8];
      end
   end

   // memory request one cycle after the operation; push wins over pop
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         stack_wr_ff <= 1'b0;
         stack_rd_ff <= 1'b0;
         stack_addr_ff <= 16'h0000;
         stack_wdata_ff <= 8'h00;
         stack_in_data_space_ff <= 1'b0;
      end else begin
         stack_wr_ff <= stack_push;
         stack_rd_ff <= stack_pop && !stack_push;
         stack_in_data_space_ff <= extended_mode;
         if (stack_push) begin
            stack_wdata_ff <= acc;
            stack_addr_ff <= extended_mode ? nxt_stack_up
                             : {8'h00, nxt_stack_up[7:0]};
         end else if (stack_pop) begin
            stack_addr_ff <= extended_mode ? stack_full
                             : {8'h00, stack_pointer_low_ff};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt progress status; writes do nothing

   // serial activity bits stay zero, no serial channel feeds them
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         interrupt_progress_status_ff <= 8'h00;
      end else begin
         interrupt_progress_status_ff <= 8'h00;
         interrupt_progress_status_ff[POS_HIGH_PRIO_IN_PROGRESS] <= hp_in_service;
         interrupt_progress_status_ff[POS_LOW_PRIO_IN_PROGRESS] <= lp_in_service;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // wait states, relocation and addressing mode

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wait_state_control_ff <= RST_WAIT_STATE;
      end else if (byte_wr(OFS_WAIT_STATE_CONTROL)) begin
         wait_state_control_ff <= sfr_wdata[WAIT_FIELD_W-1:0];
      end
   end

   // protected: an unlocked write lands, any other is dropped silently
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         external_data_memory_relocation_ff <= RST_EXTERNAL_DATA_MEMORY_RELOCATION;
      end else if (byte_wr(OFS_EXTERNAL_DATA_MEMORY_RELOCATION) && timed_access_protection) begin
         external_data_memory_relocation_ff <= sfr_wdata;
      end
   end

   // the indicator bit is not stored; it is rebuilt from the mode
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         addressing_mode_control_ff <= RST_ADDRESSING_MODE_CONTROL;
      end else if (byte_wr(OFS_ADDRESSING_MODE_CONTROL) && timed_access_protection) begin
         addressing_mode_control_ff <= sfr_wdata & MASK_ADDRESSING_MODE_WR;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read path, registered; unmapped offsets answer zero with no hit

   always_comb begin
      rd_hit = 1'b1;
      if (sfr_addr == OFS_MULTIPLY_AUX_REGISTER) begin
         rd_val = multiply_aux_register_ff;
      end else if (sfr_addr == OFS_PROGRAM_STATUS_WORD) begin
         rd_val = psw_view;
      end else if (sfr_addr == OFS_STACK_POINTER_LOW) begin
         rd_val = stack_pointer_low_ff;
      end else if (sfr_addr == OFS_STACK_POINTER_HIGH) begin
         rd_val = stack_pointer_high_ff;
      end else if (sfr_addr == OFS_INTERRUPT_PROGRESS_STATUS) begin
         rd_val = interrupt_progress_status_ff;
      end else if (sfr_addr == OFS_WAIT_STATE_CONTROL) begin
         rd_val = {4'h0, wait_state_control_ff};
      end else if (sfr_addr == OFS_EXTERNAL_DATA_MEMORY_RELOCATION) begin
         rd_val = external_data_memory_relocation_ff;
      end else if (sfr_addr == OFS_ADDRESSING_MODE_CONTROL) begin
         rd_val = addressing_mode_control_view;
      end else begin
         rd_val = 8'h00;
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         sfr_rdata_ff <= 8'h00;
         sfr_hit_ff <= 1'b0;
      end else if (sfr_rd) begin
         sfr_rdata_ff <= rd_val;
         sfr_hit_ff <= rd_hit;
      end else begin
         sfr_hit_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // helpers

   csa_wait_states #(
      .WS_W(WAIT_FIELD_W)
   ) u_wait (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .wait_field(wait_state_control_ff),
      .fetch_req(fetch_req),
      .fetch_busy(fetch_busy),
      .fetch_done(fetch_done)
   );

   csa_addr_form #(
      .PC_W(PC_W)
   ) u_addr (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .extended_mode(extended_mode),
      .vector_region_select(addressing_mode_control_ff[POS_VECTOR_REGION_SELECT]),
      .indirect_high_addr_source(addressing_mode_control_ff[POS_INDIRECT_HIGH_ADDR_SOURCE]),
      .pc_next(pc_next),
      .vector_offset(vector_offset),
      .port_two(port_two),
      .indirect_high_addr_register(indirect_high_addr_register),
      .indirect_low_addr(indirect_low_addr),
      .code_addr_ff(code_addr_ff),
      .vector_addr_ff(vector_addr_ff),
      .movx_addr_ff(movx_addr_ff)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   AST_AUX_WRITE: assert property (
      byte_wr(OFS_MULTIPLY_AUX_REGISTER) |=> multiply_aux_register_ff == $past(sfr_wdata))
      else $error("aux register write lost");

   AST_PARITY_READ: assert property (
      sfr_rd && sfr_addr == OFS_PROGRAM_STATUS_WORD |=> sfr_rdata_ff[0] == ^$past(acc))
      else $error("parity bit does not follow accumulator");

   AST_PUSH_ADDR: assert property (
      stack_push && !extended_mode
      |=> stack_wr_ff && stack_addr_ff == {8'h00, $past(stack_pointer_low_ff) + 8'h01})
      else $error("push address not one above pointer");

   AST_POP_ADDR: assert property (
      stack_pop && !stack_push && !extended_mode
      |=> stack_rd_ff && stack_addr_ff[7:0] == $past(stack_pointer_low_ff))
      else $error("pop address not equal to pointer");

   AST_EXT_STACK: assert property (
      stack_push && extended_mode |=> stack_addr_ff == $past(stack_full) + 16'h0001)
      else $error("extended push address wrong");

   AST_STATUS_RO: assert property (
      $past(nrst) && sfr_rd && sfr_addr == OFS_INTERRUPT_PROGRESS_STATUS
      |=> sfr_rdata_ff == {1'b0, $past(hp_in_service, 2), $past(lp_in_service, 2), 5'h00})
      else $error("progress status read wrong");

   AST_WAIT_RESET: assert property (
      $rose(nrst) |-> wait_state_control_ff == 4'h7)
      else $error("wait field not seven after reset");

   AST_PROTECT: assert property (
      byte_wr(OFS_ADDRESSING_MODE_CONTROL) && !timed_access_protection
      |=> $stable(addressing_mode_control_ff))
      else $error("unprotected mode write took effect");

   AST_RELOC_PROTECT: assert property (
      byte_wr(OFS_EXTERNAL_DATA_MEMORY_RELOCATION) && !timed_access_protection |=> $stable(external_data_memory_relocation_ff))
      else $error("unprotected relocation write took effect");

   AST_INDICATOR: assert property (
      sfr_rd && sfr_addr == OFS_ADDRESSING_MODE_CONTROL
      |=> sfr_rdata_ff[POS_STACK_MODE_INDICATOR] == $past(extended_mode))
      else $error("stack indicator does not follow mode");

   COV_EXT_PUSH: cover property (extended_mode && stack_push);
   COV_UNLOCKED_MODE: cover property (byte_wr(OFS_ADDRESSING_MODE_CONTROL)
                                      && timed_access_protection);
   COV_HP_READ: cover property (sfr_rd && sfr_addr == OFS_INTERRUPT_PROGRESS_STATUS
                                && hp_in_service);

endmodule

`default_nettype wire

/* File: tb/csa_core_model.sv */
`timescale 1ns/1ns
`default_nettype none

// core side stack ram: keeps only the last word it was handed
module csa_core_model (
   // clock
   input wire logic sys_clk,
   // stack write strobe from the register block
   input wire logic stack_wr_ff,
   input wire logic [15:0] stack_addr_ff,
   input wire logic [7:0] stack_wdata_ff,
   // what the ram last took
   output var logic [15:0] m_addr,
   output var logic [7:0] m_data
);
   // latch on the strobe only, so a stale address never looks written
   always_ff @(posedge sys_clk) begin
      if (stack_wr_ff) begin
         m_addr <= stack_addr_ff;
         m_data <= stack_wdata_ff;
      end
   end
endmodule

`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
   typedef struct {logic w; logic [7:0] a, d; logic t; logic [7:0] e;} csa_row_t;
   logic sys_clk = 0, nrst = 0, sfr_wr = 0, sfr_rd = 0, sfr_bit_wr = 0, sfr_bit_val = 0;
   logic timed_access_protection = 0, alu_flags_we = 0, muldiv_we = 0, stack_push = 0;
   logic stack_pop = 0, hp_in_service = 0, lp_in_service = 0, fetch_req = 0;
   logic alu_carry = 1, alu_aux_carry = 1, alu_overflow = 1;
   logic [2:0] sfr_bit_sel = 0;
   logic [7:0] sfr_addr = 0, sfr_wdata = 0, acc = 0, muldiv_aux = 8'h3c, vector_offset = 8'h0b;
   logic [7:0] port_two = 8'h12, indirect_high_addr_register = 8'h34, indirect_low_addr = 8'h56;
   logic [19:0] pc_next = 20'ha_b123, code_addr_ff;
   logic [7:0] sfr_rdata_ff, bank_select, external_data_memory_base, m_data;
   logic sfr_hit_ff, stack_wr_ff, stack_rd_ff, stack_in_data_space_ff, fetch_done, fetch_busy;
   logic [15:0] stack_addr_ff, vector_addr_ff, movx_addr_ff, m_addr;
   logic [7:0] stack_wdata_ff;
   int n_fail = 0, n_tests = 0, n;
   // reset values first, then writes with their read-back
   csa_row_t rows [18] = '{'{0, 8'h81, 0, 0, 8'h00}, '{0, 8'h92, 0, 0, 8'h07},
      '{0, 8'h9b, 0, 0, 8'h00}, '{0, 8'h9d, 0, 0, 8'h00}, '{0, 8'hc5, 0, 0, 8'h00},
      '{0, 8'hc6, 0, 0, 8'h00}, '{0, 8'hd0, 0, 0, 8'h00}, '{0, 8'hf0, 0, 0, 8'h00},
      '{1, 8'hf0, 8'ha5, 0, 8'ha5}, '{1, 8'hd0, 8'hff, 0, 8'hfe}, '{1, 8'hc5, 8'hff, 1, 8'h00},
      '{1, 8'h9d, 8'hff, 0, 8'h00}, '{1, 8'hc6, 8'h3c, 0, 8'h00}, '{1, 8'hc6, 8'h3c, 1, 8'h3c},
      '{1, 8'h92, 8'hff, 0, 8'h0f}, '{1, 8'h9b, 8'h12, 0, 8'h12}, '{1, 8'hd0, 8'h00, 0, 8'h00},
      '{1, 8'h81, 8'h07, 0, 8'h07}};

   csa_regs dut_u (.sys_clk, .nrst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_bit_wr,
      .sfr_bit_sel, .sfr_bit_val, .sfr_rdata_ff, .sfr_hit_ff, .timed_access_protection, .acc,
      .alu_flags_we, .alu_carry, .alu_aux_carry, .alu_overflow, .muldiv_we, .muldiv_aux,
      .stack_push, .stack_pop, .stack_wr_ff, .stack_rd_ff, .stack_addr_ff, .stack_wdata_ff,
      .stack_in_data_space_ff, .hp_in_service, .lp_in_service, .fetch_req, .fetch_busy,
      .fetch_done, .pc_next, .code_addr_ff, .vector_offset, .vector_addr_ff, .port_two,
      .indirect_high_addr_register, .indirect_low_addr, .movx_addr_ff, .bank_select,
      .external_data_memory_base);
   csa_core_model core_u (.sys_clk, .stack_wr_ff, .stack_addr_ff, .stack_wdata_ff, .m_addr,
      .m_data);

   initial begin
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic tally_and_finish();
      $display("fails=%0d tests=%0d", n_fail, n_tests);
      if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask

   // every driver task ends one idle edge later so strobes never retoggle in a step
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic t);
      sfr_addr = a;
      sfr_wdata = d;
      timed_access_protection = t;
      sfr_wr = 1;
      @(negedge sys_clk);
      sfr_wr = 0;
      timed_access_protection = 0;
      @(negedge sys_clk);
   endtask

   // 0x55 is the unmapped probe, so it alone must miss
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      sfr_addr = a;
      sfr_rd = 1;
      @(negedge sys_clk);
      sfr_rd = 0;
      cmp(sfr_rdata_ff, e);
      cmp(sfr_hit_ff, a != 8'h55);
      @(negedge sys_clk);
   endtask

   task automatic fc(input int e);
      fetch_req = 1;
      @(negedge sys_clk);
      fetch_req = 0;
      cmp(fetch_busy, 1'b1);
      n = 1;
      while (fetch_done !== 1'b1 && n < 40) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 40) begin
         n_fail++;
         tally_and_finish();
      end
      cmp(n, e);
      @(negedge sys_clk);
   endtask

   task automatic sk(input logic push, input logic [15:0] e);
      stack_push = push;
      stack_pop = !push;
      @(negedge sys_clk);
      stack_push = 0;
      stack_pop = 0;
      cmp(stack_addr_ff, e);
      cmp(push ? stack_wr_ff : stack_rd_ff, 1'b1);
      @(negedge sys_clk);
   endtask

   task automatic pulse(ref logic s);
      s = 1;
      @(negedge sys_clk);
      s = 0;
      @(negedge sys_clk);
   endtask

   initial begin
      repeat (5) @(negedge sys_clk);
      nrst = 1;
      @(negedge sys_clk);
      cmp(movx_addr_ff, 16'h1256);
      cmp(vector_addr_ff, 16'h000b);
      cmp(code_addr_ff, 20'h0_b123);
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d, rows[i].t);
         rd(rows[i].a, rows[i].e);
      end
      cmp(bank_select, 8'h01);
      cmp(external_data_memory_base, 8'h3c);
      wr(8'hc6, 8'h00, 1); // software puts relocation back to zero
      cmp(external_data_memory_base, 8'h00);
      rd(8'h55, 8'h00);
      fc(16);
      wr(8'h92, 8'h00, 0);
      fc(1);
      wr(8'h92, 8'h02, 0); // a 100 MHz clock needs more than one
      fc(3);
      pulse(muldiv_we);
      rd(8'hf0, 8'h3c);
      sfr_addr = 8'hf0;
      sfr_bit_val = 1;
      pulse(sfr_bit_wr);
      rd(8'hf0, 8'h3d);
      acc = 8'h01;
      pulse(alu_flags_we);
      rd(8'hd0, 8'hc5);
      hp_in_service = 1;
      lp_in_service = 1;
      @(negedge sys_clk);
      rd(8'hc5, 8'h60);
      acc = 8'h55;
      sk(1, 16'h0008);
      cmp(m_data, 8'h55);
      sk(0, 16'h0008);
      wr(8'h9d, 8'h02, 1);
      rd(8'h9d, 8'h06);
      cmp(code_addr_ff, 20'ha_b123);
      cmp(stack_in_data_space_ff, 1'b1);
      sk(1, 16'h1208);
      cmp(m_addr, 16'h1208);
      wr(8'h9d, 8'h01, 1);
      rd(8'h9d, 8'h01);
      wr(8'h9d, 8'h28, 1);
      cmp(vector_addr_ff, 16'hb00b);
      cmp(movx_addr_ff, 16'h3456);
      // mid-run reset must drop the written wait field and stack pointer high byte
      nrst = 0;
      @(negedge sys_clk);
      nrst = 1;
      rd(8'h92, 8'h07);
      rd(8'h9b, 8'h00);
      fc(8);
      tally_and_finish();
   end
endmodule

`default_nettype wire
